// ### rtl/sfc_frame_cfg.sv
// Purpose: Frame configuration, receive routing, parity and alternate event flags
// Assumes: APB slave on sys_clk, zero wait states, core signals on the same clock
// Notes: Register view switches with alt_map_select; events raise one level irq
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Loop set cuts the receive pin off and feeds transmitter output to receiver.
// - In loop, source bit picks internal link (0) or transmit pin single-wire (1).
// - Halt-in-wait set stops the block during wait mode; cleared keeps it running.
// - Character length bit selects eight data bits (0) or nine (1).
// - Wake bit selects idle-line (0) or address-mark wakeup on received MSB (1).
// - Idle count starts after start bit (0) or after stop bit (1).
// - Parity on places parity in the character MSB and checks it on receive.
// - Parity type picks even (0) or odd (1) parity.
// - Receive edge flag sets on active pin edge, falling or rising by polarity.
// - Mismatch level records the sampled receive value on a bit error.
// - Bit error flag sets when sampled receive differs from transmitted bit.
// - Break flag sets on received break while detector is on; write one clears.
// - Frame control visible only with map bit 0; alternate status only with 1.
// - Tick select 00 off, 01 samples ninth tick, 10 thirteenth, 11 reserved.
// - Break detection only works while its enable bit is set.
// - Each event flag requests interrupt only when its own enable bit is set.
module sfc_frame_cfg
    import sfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SFC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic tx_pin_in,
    input wire logic tx_core_out,
    input wire logic wait_mode,
    input wire logic break_rx,
    input wire sfc_bit_chk_t bit_chk,
    input wire logic [8:0] tx_data,
    input wire logic [8:0] rx_char,
    output logic rx_core_in,
    output logic core_enable,
    output sfc_frame_cfg_t frame_cfg,
    output logic [8:0] tx_char,
    output logic rx_parity_err,
    output logic irq
);

    // ========================================================================
    // Helpers
    function automatic sfc_reg_sel_t reg_select(input logic [SFC_ADDR_W-1:0] a,
                                                input logic alt_map_select);
        logic [2:0] idx;
        sfc_reg_sel_t sel;
        idx = a[4:2];
        sel = SFC_REG_NONE;
        if (a[1:0] == 2'h0 && a[SFC_ADDR_W-1:5] == '0) begin
            if (idx == SFC_IDX_MAP_CTRL) begin
                sel = SFC_REG_MAP;
            end else if (alt_map_select) begin
                if (idx == SFC_IDX_ALT_STATUS) begin
                    sel = SFC_REG_STATUS;
                end else if (idx == SFC_IDX_ALT_CTRL1) begin
                    sel = SFC_REG_IRQ_EN;
                end else if (idx == SFC_IDX_ALT_CTRL2) begin
                    sel = SFC_REG_CTRL2;
                end
            end else if (idx == SFC_IDX_FRAME_CTRL) begin
                sel = SFC_REG_FRAME;
            end
        end
        return sel;
    endfunction

    // Parity bit over the data bits below the parity position
    function automatic logic parity_of(input logic [8:0] d, input logic nine,
                                       input logic odd);
        logic p;
        p = nine ? ^d[7:0] : ^d[6:0];
        return p ^ odd;
    endfunction

    // ========================================================================
    // State
    sfc_state_t st_reg;
    sfc_state_t st_next;
    sfc_reg_sel_t wr_sel;
    sfc_reg_sel_t rd_sel;
    logic wr_en;
    logic rx_route;
    logic edge_hit;
    logic sample_now;
    logic mismatch;
    logic [7:0] status_rd;

    assign wr_en = psel && penable && pwrite;
    assign wr_sel = reg_select(paddr, st_reg.alt_map);
    assign rd_sel = wr_sel;

    // Receive source: loop steers away from the pin
    always_comb begin
        if (!st_reg.frame_control[SFC_FC_LOOP]) begin
            rx_route = st_reg.rx_s2;
        end else if (st_reg.frame_control[SFC_FC_RX_SRC]) begin
            rx_route = st_reg.txp_s2;
        end else begin
            rx_route = tx_core_out;
        end
    end

    // Edge seen on the pin itself, polarity decides which way is active
    assign edge_hit = st_reg.rx_inv ? (!st_reg.rx_prev && st_reg.rx_s2)
                                    : (st_reg.rx_prev && !st_reg.rx_s2);

    // Sampling moment inside a transmitted bit; reserved code checks nothing
    always_comb begin
        case (st_reg.tick_sel)
            SFC_TICK_NINTH: sample_now = bit_chk.tick_index == SFC_TICK_IDX_NINTH;
            SFC_TICK_THIRTEENTH: sample_now = bit_chk.tick_index == SFC_TICK_IDX_THIRTEENTH;
            default: sample_now = 1'b0;
        endcase
    end
    assign mismatch = bit_chk.tx_active && bit_chk.tick && sample_now
                      && (rx_route != bit_chk.tx_bit);

    always_comb begin
        status_rd = '0;
        status_rd[SFC_ST_EDGE] = st_reg.edge_f;
        status_rd[SFC_ST_MIS_LVL] = st_reg.mis_lvl;
        status_rd[SFC_ST_MIS] = st_reg.mis_f;
        status_rd[SFC_ST_BRK] = st_reg.brk_f;
    end

    // ========================================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.rx_s1 = rx_pin;
        st_next.rx_s2 = st_reg.rx_s1;
        st_next.rx_prev = st_reg.rx_s2;
        st_next.txp_s1 = tx_pin_in;
        st_next.txp_s2 = st_reg.txp_s1;
        st_next.rx_core_in = rx_route;
        st_next.core_en = !(st_reg.frame_control[SFC_FC_HALT_WAIT] && wait_mode);

        if (wr_en) begin
            case (wr_sel)
                SFC_REG_FRAME: st_next.frame_control = pwdata[7:0];
                SFC_REG_IRQ_EN: begin
                    st_next.edge_ie = pwdata[SFC_ST_EDGE];
                    st_next.mis_ie = pwdata[SFC_ST_MIS];
                    st_next.brk_ie = pwdata[SFC_ST_BRK];
                end
                SFC_REG_CTRL2: begin
                    st_next.tick_sel = pwdata[SFC_C2_TICK_HI:SFC_C2_TICK_LO];
                    st_next.brk_on = pwdata[SFC_C2_BRK_ON];
                end
                SFC_REG_MAP: begin
                    st_next.alt_map = pwdata[SFC_MC_ALT_MAP];
                    st_next.rx_inv = pwdata[SFC_MC_RX_INV];
                end
                SFC_REG_STATUS: begin
                    // Only ones clear; zeros leave the flag as it stands
                    if (pwdata[SFC_ST_EDGE]) st_next.edge_f = 1'b0;
                    if (pwdata[SFC_ST_MIS]) st_next.mis_f = 1'b0;
                    if (pwdata[SFC_ST_BRK]) st_next.brk_f = 1'b0;
                end
                default: st_next.frame_control = st_reg.frame_control;
            endcase
        end

        // Events applied after the clear so a coincident set wins
        if (edge_hit) st_next.edge_f = 1'b1;
        if (mismatch) begin
            st_next.mis_f = 1'b1;
            st_next.mis_lvl = rx_route;
        end
        if (st_reg.brk_on && break_rx) st_next.brk_f = 1'b1;

        // Parity goes into the top bit of the character
        st_next.tx_char = tx_data;
        st_next.rx_par_err = 1'b0;
        if (st_reg.frame_control[SFC_FC_PARITY_ON]) begin
            if (st_reg.frame_control[SFC_FC_NINE_BIT]) begin
                st_next.tx_char[8] = parity_of(tx_data, 1'b1,
                                               st_reg.frame_control[SFC_FC_ODD_PARITY]);
                st_next.rx_par_err = rx_char[8] != parity_of(rx_char, 1'b1,
                                          st_reg.frame_control[SFC_FC_ODD_PARITY]);
            end else begin
                st_next.tx_char[7] = parity_of(tx_data, 1'b0,
                                               st_reg.frame_control[SFC_FC_ODD_PARITY]);
                st_next.rx_par_err = rx_char[7] != parity_of(rx_char, 1'b0,
                                          st_reg.frame_control[SFC_FC_ODD_PARITY]);
            end
        end

        // Read data captured in the setup cycle so prdata is a flop output
        if (psel && !penable) begin
            st_next.rdata = '0;
            st_next.slverr = rd_sel == SFC_REG_NONE;
            case (rd_sel)
                SFC_REG_FRAME: st_next.rdata[7:0] = st_reg.frame_control;
                SFC_REG_STATUS: st_next.rdata[7:0] = status_rd;
                SFC_REG_IRQ_EN: begin
                    st_next.rdata[SFC_ST_EDGE] = st_reg.edge_ie;
                    st_next.rdata[SFC_ST_MIS] = st_reg.mis_ie;
                    st_next.rdata[SFC_ST_BRK] = st_reg.brk_ie;
                end
                SFC_REG_CTRL2: begin
                    st_next.rdata[SFC_C2_TICK_HI:SFC_C2_TICK_LO] = st_reg.tick_sel;
                    st_next.rdata[SFC_C2_BRK_ON] = st_reg.brk_on;
                end
                SFC_REG_MAP: begin
                    st_next.rdata[SFC_MC_ALT_MAP] = st_reg.alt_map;
                    st_next.rdata[SFC_MC_RX_INV] = st_reg.rx_inv;
                end
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Samplers start at the idle level so the release cannot fake a pin edge
            st_reg <= '0;
            st_reg.rx_s1 <= SFC_LINE_IDLE;
            st_reg.rx_s2 <= SFC_LINE_IDLE;
            st_reg.rx_prev <= SFC_LINE_IDLE;
            st_reg.txp_s1 <= SFC_LINE_IDLE;
            st_reg.txp_s2 <= SFC_LINE_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================================================
    // Outputs
    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.slverr;
    assign pready = 1'b1;
    assign rx_core_in = st_reg.rx_core_in;
    assign core_enable = st_reg.core_en;
    assign tx_char = st_reg.tx_char;
    assign rx_parity_err = st_reg.rx_par_err;
    always_comb begin
        frame_cfg.nine_bit = st_reg.frame_control[SFC_FC_NINE_BIT];
        frame_cfg.wake_addr_mark = st_reg.frame_control[SFC_FC_WAKE];
        frame_cfg.idle_count_start = st_reg.frame_control[SFC_FC_IDLE_START];
        frame_cfg.parity_on = st_reg.frame_control[SFC_FC_PARITY_ON];
        frame_cfg.odd_parity_select = st_reg.frame_control[SFC_FC_ODD_PARITY];
    end
    assign irq = (st_reg.edge_f && st_reg.edge_ie) || (st_reg.mis_f && st_reg.mis_ie)
                 || (st_reg.brk_f && st_reg.brk_ie);

    // ========================================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_NORMAL_ROUTE: assert property (!st_reg.frame_control[SFC_FC_LOOP]
        |=> rx_core_in == $past(st_reg.rx_s2)) else $error("pin not routed");
    AST_LOOP_ROUTE: assert property (st_reg.frame_control[SFC_FC_LOOP]
        && !st_reg.frame_control[SFC_FC_RX_SRC] |=> rx_core_in == $past(tx_core_out))
        else $error("loop route wrong");
    AST_SINGLE_WIRE: assert property (st_reg.frame_control[SFC_FC_LOOP]
        && st_reg.frame_control[SFC_FC_RX_SRC] |=> rx_core_in == $past(st_reg.txp_s2))
        else $error("single wire route wrong");
    AST_WAIT_HALT: assert property (st_reg.frame_control[SFC_FC_HALT_WAIT] && wait_mode
        |=> !core_enable) else $error("not halted in wait");
    AST_EDGE_SET: assert property (!st_reg.rx_inv && st_reg.rx_prev && !st_reg.rx_s2
        |=> st_reg.edge_f) else $error("edge flag missed");
    AST_EDGE_INV: assert property (st_reg.rx_inv && !st_reg.rx_prev && st_reg.rx_s2
        |=> st_reg.edge_f) else $error("rising edge flag missed");
    AST_MISMATCH: assert property (mismatch
        |=> st_reg.mis_f && st_reg.mis_lvl == $past(rx_route))
        else $error("bit error not recorded");
    AST_BRK_SET: assert property (st_reg.brk_on && break_rx
        |=> st_reg.brk_f) else $error("break flag missed");
    AST_BRK_OFF: assert property (!st_reg.brk_on && !st_reg.brk_f
        |=> !st_reg.brk_f) else $error("break flag without detector");
    AST_IRQ_MASK: assert property (!st_reg.edge_ie && !st_reg.mis_ie && !st_reg.brk_ie
        |-> !irq) else $error("irq while all masked");
    AST_W1C_ZERO: assert property (wr_en && wr_sel == SFC_REG_STATUS
        && pwdata[SFC_ST_BRK] == 1'b0 && st_reg.brk_f |=> st_reg.brk_f)
        else $error("zero write cleared flag");
    AST_MAP_HIDE: assert property (psel && !penable && !st_reg.alt_map
        && paddr == {3'h0, SFC_IDX_ALT_STATUS, 2'h0} |=> pslverr && prdata == '0)
        else $error("status visible with map clear");
    AST_MAP_FRAME: assert property (psel && !penable && !st_reg.alt_map
        && paddr == {3'h0, SFC_IDX_FRAME_CTRL, 2'h0}
        |=> !pslverr && prdata[7:0] == $past(st_reg.frame_control))
        else $error("frame control not readable");
    AST_PARITY: assert property (st_reg.frame_control[SFC_FC_PARITY_ON]
        && !st_reg.frame_control[SFC_FC_NINE_BIT] && $stable(st_reg.frame_control)
        |=> (^tx_char[7:0]) == $past(st_reg.frame_control[SFC_FC_ODD_PARITY]))
        else $error("transmit parity wrong");
    AST_PARITY_NINE: assert property (st_reg.frame_control[SFC_FC_PARITY_ON]
        && st_reg.frame_control[SFC_FC_NINE_BIT]
        |=> (^tx_char) == $past(st_reg.frame_control[SFC_FC_ODD_PARITY]))
        else $error("nine bit parity wrong");

endmodule
`default_nettype wire

// ### shared/sfc_pkg.sv
// Purpose: Shared constants and types of the serial frame configuration block
// Assumes: 32-bit APB data, one register per aligned word, byte address = 4 x index
// Notes: Index values are the register offsets; the bus address is four times them
package sfc_pkg;

    // ========================================================================
    // Register indices (byte address = index * 4)
    localparam logic [2:0] SFC_IDX_ALT_STATUS = 3'h0;
    localparam logic [2:0] SFC_IDX_ALT_CTRL1 = 3'h1;
    localparam logic [2:0] SFC_IDX_FRAME_CTRL = 3'h2;
    localparam logic [2:0] SFC_IDX_ALT_CTRL2 = 3'h2;
    localparam logic [2:0] SFC_IDX_MAP_CTRL = 3'h5;
    localparam int SFC_ADDR_W = 8;
    // Serial lines idle high; the pin samplers start from that level
    localparam logic SFC_LINE_IDLE = 1'b1;

    // ========================================================================
    // Field positions
    localparam int SFC_FC_LOOP = 7;
    localparam int SFC_FC_HALT_WAIT = 6;
    localparam int SFC_FC_RX_SRC = 5;
    localparam int SFC_FC_NINE_BIT = 4;
    localparam int SFC_FC_WAKE = 3;
    localparam int SFC_FC_IDLE_START = 2;
    localparam int SFC_FC_PARITY_ON = 1;
    localparam int SFC_FC_ODD_PARITY = 0;
    localparam int SFC_ST_EDGE = 7;
    localparam int SFC_ST_MIS_LVL = 2;
    localparam int SFC_ST_MIS = 1;
    localparam int SFC_ST_BRK = 0;
    localparam int SFC_C2_TICK_HI = 2;
    localparam int SFC_C2_TICK_LO = 1;
    localparam int SFC_C2_BRK_ON = 0;
    localparam int SFC_MC_ALT_MAP = 7;
    localparam int SFC_MC_RX_INV = 3;

    // ========================================================================
    // Bit check sample ticks (tick index counts 0..15 within a bit)
    localparam logic [1:0] SFC_TICK_OFF = 2'h0;
    localparam logic [1:0] SFC_TICK_NINTH = 2'h1;
    localparam logic [1:0] SFC_TICK_THIRTEENTH = 2'h2;
    localparam logic [3:0] SFC_TICK_IDX_NINTH = 4'h8;
    localparam logic [3:0] SFC_TICK_IDX_THIRTEENTH = 4'hC;

    typedef enum logic [2:0] {
        SFC_REG_NONE = 3'b000,
        SFC_REG_STATUS = 3'b001,
        SFC_REG_IRQ_EN = 3'b010,
        SFC_REG_FRAME = 3'b011,
        SFC_REG_CTRL2 = 3'b100,
        SFC_REG_MAP = 3'b101
    } sfc_reg_sel_t;

    // Frame settings handed to the serial core
    typedef struct packed {
        logic nine_bit;
        logic wake_addr_mark;
        logic idle_count_start;
        logic parity_on;
        logic odd_parity_select;
    } sfc_frame_cfg_t;

    // Transmitter bit check inputs from the serial core
    typedef struct packed {
        logic tx_active;
        logic tick;
        logic [3:0] tick_index;
        logic tx_bit;
    } sfc_bit_chk_t;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic txp_s1;
        logic txp_s2;
        logic [7:0] frame_control;
        logic edge_f;
        logic mis_lvl;
        logic mis_f;
        logic brk_f;
        logic edge_ie;
        logic mis_ie;
        logic brk_ie;
        logic [1:0] tick_sel;
        logic brk_on;
        logic alt_map;
        logic rx_inv;
        logic rx_core_in;
        logic core_en;
        logic [8:0] tx_char;
        logic rx_par_err;
        logic [31:0] rdata;
        logic slverr;
    } sfc_state_t;

endpackage

// ### test/sfc_frame_cfg_test.sv
// Purpose: Self-checking bench for the frame configuration and alternate status block
// Assumes: APB master on sys_clk at 40 MHz, remote node model on the serial lines
// Notes: Random stimulus from a fixed-seed xorshift, corner cases written by hand
`timescale 1ns/10ps
`default_nettype none
module sfc_frame_cfg_test
    import sfc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [SFC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd_q;
    logic [31:0] seed = 32'hD803;
    logic pready, pslverr, err_q, rx_pin, tx_pin_in, rx_core_in, core_enable, irq, rx_parity_err;
    logic tx_core_out = 1'b0, rx_low = 1'b0, tx_low = 1'b0, wait_mode = 1'b0, break_rx = 1'b0;
    sfc_bit_chk_t bit_chk = '0;
    sfc_frame_cfg_t frame_cfg;
    logic [8:0] tx_data = '0, rx_char = '0, tx_char;
    int errors = 0, cmp_count = 0;

    sfc_frame_cfg DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin_in(tx_pin_in), .tx_core_out(tx_core_out),
        .wait_mode(wait_mode), .break_rx(break_rx), .bit_chk(bit_chk), .tx_data(tx_data),
        .rx_char(rx_char), .rx_core_in(rx_core_in), .core_enable(core_enable),
        .frame_cfg(frame_cfg), .tx_char(tx_char), .rx_parity_err(rx_parity_err), .irq(irq));
    sfc_remote_node node (.tx_core_out(tx_core_out), .rx_low(rx_low), .tx_low(tx_low),
        .rx_pin(rx_pin), .tx_pin_in(tx_pin_in));

    always #12.5 sys_clk = ~sys_clk;

    // =========================================================================
    // Helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Parity covers the data below it and lands in the top bit of the character
    function automatic logic [8:0] exp_tx(input logic [4:0] cfg, input logic [8:0] d);
        logic [8:0] r;
        r = d;
        if (cfg[1] && cfg[4]) r[8] = ^d[7:0] ^ cfg[0];
        if (cfg[1] && !cfg[4]) r[7] = ^d[6:0] ^ cfg[0];
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One APB transfer; an idle cycle follows so the next setup never lands on the release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp,
        input logic e, input string what);
        apb(1'b0, a, 8'h00);
        chk(rd_q & {24'h0, m}, {24'h0, exp & m}, what);
        chk({31'h0, err_q}, {31'h0, e}, what);
    endtask
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, {31'h0, exp}, "irq");
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("unexpected at %0t: run hung", $time);
        wrap_up();
    end

    // =========================================================================
    // Tests
    initial begin
        logic [31:0] tmp;
        logic [8:0] m;
        logic [7:0] v;
        logic [1:0] sel;
        logic lvl, flag, exp_b;
        int i;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        irq_chk(1'b0);
        rd_chk(8'h14, 8'hFF, 8'h00, 1'b0, "map reset");
        rd_chk(8'h08, 8'hFF, 8'h00, 1'b0, "frame reset");
        rd_chk(8'h00, 8'hFF, 8'h00, 1'b1, "status hidden");
        rd_chk(8'h0C, 8'hFF, 8'h00, 1'b1, "unmapped");
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            tmp = rnd();
            v = tmp[7:0];
            apb(1'b1, 8'h08, v);
            wait_mode <= tmp[9];
            tx_data <= tmp[24:16];
            rx_char <= tmp[18:10];
            repeat (2) @(posedge sys_clk);
            m = v[4] ? 9'h1FF : 9'h0FF;
            chk({27'h0, frame_cfg}, {27'h0, v[4:0]}, "frame cfg");
            chk({31'h0, core_enable}, {31'h0, ~(v[6] & tmp[9])}, "core enable");
            chk({23'h0, tx_char & m}, {23'h0, exp_tx(v[4:0], tx_data) & m}, "tx char");
            exp_b = ((exp_tx(v[4:0], rx_char) ^ rx_char) & m) != 9'h000;
            chk({31'h0, rx_parity_err}, {31'h0, exp_b}, "rx parity");
            rd_chk(8'h08, 8'hFF, v, 1'b0, "frame readback");
        end
        wait_mode <= 1'b0;
        $display("test frame done");
        // Bench walks the loop and source bits: pin route, internal link and single-wire loop
        for (i = 0; i < 12; i++) begin
            tmp = rnd();
            apb(1'b1, 8'h08, {i[0], 1'b0, i[1], 5'h00});
            rx_low <= tmp[2];
            tx_core_out <= tmp[3];
            tx_low <= tmp[4];
            repeat (4) @(posedge sys_clk);
            exp_b = !i[0] ? ~tmp[2] : (i[1] ? (tmp[3] & ~tmp[4]) : tmp[3]);
            chk({31'h0, rx_core_in}, {31'h0, exp_b}, "route");
        end
        $display("test route done");
        rx_low <= 1'b0;
        tx_low <= 1'b0;
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h14, 8'h80);
        rd_chk(8'h08, 8'hFF, 8'h00, 1'b0, "alt view");
        repeat (4) @(posedge sys_clk);
        apb(1'b1, 8'h00, 8'h87);
        rx_low <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd_chk(8'h00, 8'h80, 8'h80, 1'b0, "edge fall");
        irq_chk(1'b0);
        apb(1'b1, 8'h04, 8'h80);
        irq_chk(1'b1);
        apb(1'b1, 8'h00, 8'h00);
        rd_chk(8'h00, 8'h80, 8'h80, 1'b0, "write zero");
        apb(1'b1, 8'h00, 8'h80);
        irq_chk(1'b0);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, 8'h14, {1'b1, 3'h0, i > 0, 3'h0});
            rx_low <= (i == 1);
            repeat (5) @(posedge sys_clk);
            rd_chk(8'h00, 8'h80, {i == 2, 7'h00}, 1'b0, "edge polarity");
            apb(1'b1, 8'h00, 8'h80);
        end
        $display("test edge done");
        apb(1'b1, 8'h04, 8'h01);
        for (i = 0; i < 2; i++) begin
            apb(1'b1, 8'h08, {7'h00, i[0]});
            break_rx <= 1'b1;
            @(posedge sys_clk);
            break_rx <= 1'b0;
            rd_chk(8'h00, 8'h01, {7'h00, i[0]}, 1'b0, "break");
            irq_chk(i[0]);
        end
        fork
            apb(1'b1, 8'h00, 8'h01);
            begin
                @(posedge sys_clk);
                break_rx <= 1'b1;
                @(posedge sys_clk);
                break_rx <= 1'b0;
            end
        join
        rd_chk(8'h00, 8'h01, 8'h01, 1'b0, "set beats clear");
        apb(1'b1, 8'h00, 8'h86);
        rd_chk(8'h00, 8'h01, 8'h01, 1'b0, "break kept");
        apb(1'b1, 8'h00, 8'h01);
        rd_chk(8'h00, 8'h01, 8'h00, 1'b0, "break cleared");
        $display("test break done");
        apb(1'b1, 8'h04, 8'h02);
        for (i = 0; i < 16; i++) begin
            tmp = rnd();
            lvl = tmp[0];
            sel = i[2:1];
            apb(1'b1, 8'h08, {5'h00, sel, 1'b0});
            rx_low <= ~lvl;
            bit_chk <= '{1'b1, 1'b0, (i[0] ? 4'hC : 4'h8), ~lvl};
            repeat (4) @(posedge sys_clk);
            apb(1'b1, 8'h00, 8'h87);
            bit_chk.tick <= 1'b1;
            @(posedge sys_clk);
            bit_chk.tick <= 1'b0;
            flag = (sel == 2'h1 && !i[0]) || (sel == 2'h2 && i[0]);
            rd_chk(8'h00, flag ? 8'h06 : 8'h02, {5'h00, lvl, flag, 1'b0}, 1'b0, "bit chk");
            irq_chk(flag);
        end
        $display("test bit check done");
        // Reset in mid-run with a released line: registers clear, no false edge
        rst_n <= 1'b0;
        rx_low <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        irq_chk(1'b0);
        rd_chk(8'h14, 8'hFF, 8'h00, 1'b0, "map after reset");
        rd_chk(8'h08, 8'hFF, 8'h00, 1'b0, "frame after reset");
        $display("test second reset done");
        wrap_up();
    end
endmodule
`default_nettype wire

// ### test/sfc_remote_node.sv
// Purpose: Remote serial node on the receive line and the shared single-wire line
// Assumes: Lines idle high; the node only ever pulls a line low
// Notes: Behavioural; the lines settle at once, with no bit timing
`timescale 1ns/10ps
`default_nettype none
module sfc_remote_node (
    input wire logic tx_core_out,
    input wire logic rx_low,
    input wire logic tx_low,
    output logic rx_pin,
    output logic tx_pin_in
);
    // =========================================================================
    // Line levels
    // Receive line has a pull-up, so a released line reads high
    assign rx_pin = ~rx_low;
    // Single-wire line is wired-and: either party can hold it low
    assign tx_pin_in = tx_core_out & ~tx_low;
endmodule
`default_nettype wire
